// ### core/rtd_datapath.sv
// module: register-transfer datapath with working registers, flags and line buffer hooks
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module rtd_datapath
(
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire rtd_pkg::rtd_instr_t instr,
	output logic instr_ready,
	input wire rtd_pkg::rtd_line_t rx_line,
	input wire rtd_pkg::rtd_line_t switch_line,
	output logic [4:0] line_addr,
	output rtd_pkg::rtd_line_t tx_line,
	output logic tx_load,
	output logic receive_clear_pulse,
	output logic transmit_clear_pulse,
	output logic flag_plus,
	output logic flag_zero,
	output logic flag_even,
	input wire rtd_pkg::rtd_bus_req_t bus,
	output logic [17:0] rdata
);
	// ==========================================================
	// state
	rtd_pkg::rtd_state_t cur;
	rtd_pkg::rtd_state_t next_cur;
	rtd_pkg::rtd_line_t src_or;
	logic [17:0] z;
	logic line_src;

	// ==========================================================
	// operation network
	rtd_shifter u_shifter
	(
		.op(cur.ins.op),
		.y(cur.y.data),
		.link_bit(cur.b[rtd_pkg::DATA_W-1]),
		.z(z)
	);

	// ==========================================================
	// source gathering
	always_comb
	begin
		src_or = '0;
		if (cur.ins.sel[rtd_pkg::SEL_SRC_A])
		begin
			src_or.data = src_or.data | cur.a;
		end
		if (cur.ins.sel[rtd_pkg::SEL_SRC_B])
		begin
			src_or.data = src_or.data | cur.b;
		end
		if (cur.ins.sel[rtd_pkg::SEL_SRC_C])
		begin
			src_or.data = src_or.data | cur.c;
		end
		if (cur.ins.sel[rtd_pkg::SEL_SRC_Q])
		begin
			src_or.data = src_or.data | cur.q;
		end
		// receive line, registered twice, from the buffer that X addressed two cycles earlier
		if (cur.ins.sel[rtd_pkg::SEL_SRC_R])
		begin
			src_or = src_or | cur.rx_s2;
		end
		if (cur.ins.sel[rtd_pkg::SEL_SRC_S])
		begin
			src_or = src_or | cur.sw_s2;
		end
	end

	assign line_src = cur.ins.sel[rtd_pkg::SEL_SRC_R] | cur.ins.sel[rtd_pkg::SEL_SRC_S];

	// ==========================================================
	// next state
	always_comb
	begin
		next_cur = cur;
		next_cur.rx_s1 = rx_line;
		next_cur.rx_s2 = cur.rx_s1;
		next_cur.sw_s1 = switch_line;
		next_cur.sw_s2 = cur.sw_s1;
		next_cur.tx_load = 1'b0;
		next_cur.transmit_clear_pulse = 1'b0;
		next_cur.receive_clear_pulse = 1'b0;
		next_cur.rdata = '0;
		if (bus.rd)
		begin
			case (bus.addr)
				rtd_pkg::ADDR_A: next_cur.rdata = cur.a;
				rtd_pkg::ADDR_B: next_cur.rdata = cur.b;
				rtd_pkg::ADDR_C: next_cur.rdata = cur.c;
				rtd_pkg::ADDR_Q: next_cur.rdata = cur.q;
				rtd_pkg::ADDR_X: next_cur.rdata = {13'h0000, cur.x};
				rtd_pkg::ADDR_FLAGS:
				begin
					next_cur.rdata[rtd_pkg::FLAG_PLUS] = cur.plus;
					next_cur.rdata[rtd_pkg::FLAG_ZERO] = cur.zero;
					next_cur.rdata[rtd_pkg::FLAG_EVEN] = cur.even;
					next_cur.rdata[rtd_pkg::FLAG_CB1] = cur.cb1;
					next_cur.rdata[rtd_pkg::FLAG_CB2] = cur.cb2;
					next_cur.rdata[rtd_pkg::FLAG_PAR] = cur.par;
				end
				default: next_cur.rdata = '0;
			endcase
		end
		if (bus.wr)
		begin
			case (bus.addr)
				rtd_pkg::ADDR_A: next_cur.a = bus.wdata;
				rtd_pkg::ADDR_B: next_cur.b = bus.wdata;
				rtd_pkg::ADDR_C: next_cur.c = bus.wdata;
				rtd_pkg::ADDR_Q: next_cur.q = bus.wdata;
				rtd_pkg::ADDR_X: next_cur.x = bus.wdata[4:0];
				default: next_cur.x = cur.x;
			endcase
		end
		case (cur.fsm)
			rtd_pkg::ST_IDLE:
			begin
				if (instr_valid)
				begin
					next_cur.ins = instr;
					next_cur.fsm = rtd_pkg::ST_LOAD;
					// transmit buffer cleared ahead of the data
					next_cur.transmit_clear_pulse = instr.sel[rtd_pkg::SEL_DST_T];
				end
			end
			rtd_pkg::ST_LOAD:
			begin
				// zero when no source is selected
				next_cur.y = src_or;
				next_cur.fsm = rtd_pkg::ST_WRITE;
			end
			rtd_pkg::ST_WRITE:
			begin
				// flags always follow the result, even with no destination
				next_cur.plus = ~z[rtd_pkg::DATA_W-1];
				next_cur.zero = (z == 18'h00000);
				next_cur.even = ~z[0];
				if (line_src)
				begin
					next_cur.cb1 = cur.y.cb1;
					next_cur.cb2 = cur.y.cb2;
					next_cur.par = cur.y.par;
				end
				if (cur.ins.sel[rtd_pkg::SEL_DST_A])
				begin
					next_cur.a = z;
				end
				if (cur.ins.sel[rtd_pkg::SEL_DST_B])
				begin
					next_cur.b = z;
				end
				if (cur.ins.sel[rtd_pkg::SEL_DST_C])
				begin
					next_cur.c = z;
				end
				if (cur.ins.sel[rtd_pkg::SEL_DST_T])
				begin
					next_cur.tx.data = z;
					next_cur.tx.cb1 = line_src ? cur.y.cb1 : cur.cb1;
					next_cur.tx.cb2 = line_src ? cur.y.cb2 : cur.cb2;
					next_cur.tx.par = line_src ? cur.y.par : cur.par;
					next_cur.tx_load = 1'b1;
				end
				// receive buffer released once its data is in Y
				next_cur.receive_clear_pulse = cur.ins.sel[rtd_pkg::SEL_SRC_R];
				next_cur.fsm = rtd_pkg::ST_IDLE;
			end
			default:
			begin
				next_cur.fsm = rtd_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cur <= '0;
			cur.fsm <= rtd_pkg::ST_IDLE;
			cur.a <= rtd_pkg::RESET_WORD;
			cur.b <= rtd_pkg::RESET_WORD;
			cur.c <= rtd_pkg::RESET_WORD;
			cur.q <= rtd_pkg::RESET_WORD;
			cur.x <= rtd_pkg::RESET_X;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	// ==========================================================
	// outputs
	assign instr_ready = (cur.fsm == rtd_pkg::ST_IDLE);
	assign line_addr = cur.x;
	assign tx_line = cur.tx;
	assign tx_load = cur.tx_load;
	assign receive_clear_pulse = cur.receive_clear_pulse;
	assign transmit_clear_pulse = cur.transmit_clear_pulse;
	assign flag_plus = cur.plus;
	assign flag_zero = cur.zero;
	assign flag_even = cur.even;
	assign rdata = cur.rdata;

	// ==========================================================
	// checks
	default clocking cb_main @(posedge clk);
	endclocking
	default disable iff (rst);

	logic accept;
	logic bus_wr_a;
	assign accept = instr_valid & instr_ready;
	assign bus_wr_a = bus.wr & (bus.addr == rtd_pkg::ADDR_A);

	chk_or_holds_a: assert property (
		(cur.fsm == rtd_pkg::ST_LOAD) && cur.ins.sel[rtd_pkg::SEL_SRC_A]
		|=> ((cur.y.data & $past(cur.a)) == $past(cur.a)))
		else $error("A missing from the intermediate OR");

	chk_empty_src_zero: assert property (
		(cur.fsm == rtd_pkg::ST_LOAD) && (cur.ins.sel[10:5] == 6'h00)
		|=> (cur.y == '0))
		else $error("intermediate not zero with no source");

	chk_dest_a_write: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE) && cur.ins.sel[rtd_pkg::SEL_DST_A]
		|=> (cur.a == $past(z)))
		else $error("A did not take the result");

	chk_source_kept: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE) && !cur.ins.sel[rtd_pkg::SEL_DST_A] && !bus_wr_a
		|=> $stable(cur.a))
		else $error("A changed without being a destination");

	chk_tx_clear_order: assert property (
		accept && instr.sel[rtd_pkg::SEL_DST_T]
		|=> transmit_clear_pulse ##2 (tx_load && !transmit_clear_pulse))
		else $error("transmit clear not ahead of the load");

	chk_rx_clear_after: assert property (
		(cur.fsm == rtd_pkg::ST_LOAD) && cur.ins.sel[rtd_pkg::SEL_SRC_R]
		|-> !receive_clear_pulse ##2 receive_clear_pulse)
		else $error("receive clear missing after transfer");

	chk_zero_flag: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE)
		|=> (flag_zero == ($past(z) == 18'h00000)) && (flag_plus == !$past(z[17])))
		else $error("zero or plus flag wrong");

	chk_complement_op: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE) && (cur.ins.op == rtd_pkg::complement_transfer_op)
		|-> (z ^ cur.y.data) == 18'h3FFFF)
		else $error("complement result wrong");

	chk_rotate_six: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE) && (cur.ins.op == rtd_pkg::rotate_left_six_op)
		|-> (z[5:0] == cur.y.data[17:12]) && (z[17:6] == cur.y.data[11:0]))
		else $error("six-place rotate wrong");

	chk_word_time: assert property (
		accept |=> !instr_ready [*2] ##1 instr_ready)
		else $error("transfer did not take one word time");

	chk_y_or_b: assert property (
		(cur.fsm == rtd_pkg::ST_LOAD) && cur.ins.sel[rtd_pkg::SEL_SRC_B]
		|=> ((cur.y.data & $past(cur.b)) == $past(cur.b)))
		else $error("B missing from the intermediate OR");

	chk_dest_b_write: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE) && cur.ins.sel[rtd_pkg::SEL_DST_B]
		|=> (cur.b == $past(z)))
		else $error("B did not take the result");

	chk_dest_c_write: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE) && cur.ins.sel[rtd_pkg::SEL_DST_C]
		|=> (cur.c == $past(z)))
		else $error("C did not take the result");

	chk_tx_data_load: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE) && cur.ins.sel[rtd_pkg::SEL_DST_T]
		|=> tx_load && (tx_line.data == $past(z)))
		else $error("transmit line did not take the result");

	chk_line_extra_bits: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE) && line_src
		|=> (cur.cb1 == $past(cur.y.cb1)) && (cur.cb2 == $past(cur.y.cb2)) && (cur.par == $past(cur.y.par)))
		else $error("extra line bits not in the control flops");

	chk_tx_extra_flops: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE) && cur.ins.sel[rtd_pkg::SEL_DST_T] && !line_src
		|=> (tx_line.cb1 == $past(cur.cb1)) && (tx_line.cb2 == $past(cur.cb2)) && (tx_line.par == $past(cur.par)))
		else $error("transmit extra bits not from the control flops");

	chk_even_flag: assert property (
		(cur.fsm == rtd_pkg::ST_WRITE)
		|=> (flag_even == !$past(z[0])))
		else $error("even flag wrong");

	chk_pass_op: assert property (
		(cur.ins.op == rtd_pkg::pass_transfer_op)
		|-> (z == cur.y.data))
		else $error("pass result wrong");

	chk_shift_left_one: assert property (
		(cur.ins.op == rtd_pkg::shift_left_single_op)
		|-> (z == {cur.y.data[16:0], 1'b0}))
		else $error("single left shift wrong");

	chk_shift_right_six: assert property (
		(cur.ins.op == rtd_pkg::shift_right_six_op)
		|-> (z[17:12] == 6'h00) && (z[11:0] == cur.y.data[17:6]))
		else $error("six-place right shift wrong");

	chk_rotate_right_one: assert property (
		(cur.ins.op == rtd_pkg::rotate_right_single_op)
		|-> (z == {cur.y.data[0], cur.y.data[17:1]}))
		else $error("single right rotate wrong");

	chk_linked_shift: assert property (
		(cur.ins.op == rtd_pkg::linked_left_shift_op)
		|-> (z == {cur.y.data[16:0], cur.b[17]}))
		else $error("linked left shift wrong");

	chk_rx_pulse_only_r: assert property (
		receive_clear_pulse
		|-> $past(cur.fsm == rtd_pkg::ST_WRITE) && $past(cur.ins.sel[rtd_pkg::SEL_SRC_R]))
		else $error("receive clear without a receive source");

	chk_tx_pulse_only_t: assert property (
		transmit_clear_pulse
		|-> $past(accept) && $past(instr.sel[rtd_pkg::SEL_DST_T]))
		else $error("transmit clear without a transmit destination");

	cov_receive_src: cover property (accept && instr.sel[rtd_pkg::SEL_SRC_R]);
	cov_no_dest: cover property (accept && (instr.sel[4:1] == 4'h0));
	cov_transmit_dst: cover property (accept && instr.sel[rtd_pkg::SEL_DST_T]);
	cov_multi_dst: cover property (accept && (instr.sel[4:2] == 3'h7));
	cov_linked_shift: cover property (accept && (instr.op == rtd_pkg::linked_left_shift_op));
endmodule

// ### core/rtd_pkg.sv
// package: constants and types of the register-transfer datapath
// ==========================================================
package rtd_pkg;
	// ==========================================================
	// widths
	localparam int DATA_W = 18;
	localparam int LINE_ADDR_W = 5;
	localparam int SHIFT_SIX = 6;
	// ==========================================================
	// instruction select bit positions
	localparam int SEL_SRC_A = 10;
	localparam int SEL_SRC_B = 9;
	localparam int SEL_SRC_C = 8;
	localparam int SEL_SRC_Q = 7;
	localparam int SEL_SRC_R = 6;
	localparam int SEL_SRC_S = 5;
	localparam int SEL_DST_A = 4;
	localparam int SEL_DST_B = 3;
	localparam int SEL_DST_C = 2;
	localparam int SEL_DST_T = 1;
	// ==========================================================
	// register port offsets
	localparam logic [2:0] ADDR_A = 3'h0;
	localparam logic [2:0] ADDR_B = 3'h1;
	localparam logic [2:0] ADDR_C = 3'h2;
	localparam logic [2:0] ADDR_Q = 3'h3;
	localparam logic [2:0] ADDR_X = 3'h4;
	localparam logic [2:0] ADDR_FLAGS = 3'h5;
	// flags register field positions
	localparam int FLAG_PLUS = 0;
	localparam int FLAG_ZERO = 1;
	localparam int FLAG_EVEN = 2;
	localparam int FLAG_CB1 = 3;
	localparam int FLAG_CB2 = 4;
	localparam int FLAG_PAR = 5;
	// values after reset
	localparam logic [17:0] RESET_WORD = 18'h00000;
	localparam logic [4:0] RESET_X = 5'h00;
	// ==========================================================
	// types
	typedef enum logic [3:0] {
		pass_transfer_op = 4'h0,
		complement_transfer_op = 4'h1,
		shift_left_single_op = 4'h2,
		shift_right_single_op = 4'h3,
		shift_left_six_op = 4'h4,
		shift_right_six_op = 4'h5,
		rotate_left_single_op = 4'h6,
		rotate_right_single_op = 4'h7,
		rotate_left_six_op = 4'h8,
		rotate_right_six_op = 4'h9,
		linked_left_shift_op = 4'hA
	} rtd_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOAD = 2'h1,
		ST_WRITE = 2'h2
	} rtd_fsm_t;
	typedef struct packed {
		rtd_op_t op;
		logic [10:1] sel;
	} rtd_instr_t;
	typedef struct packed {
		logic cb1;
		logic cb2;
		logic par;
		logic [17:0] data;
	} rtd_line_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] addr;
		logic [17:0] wdata;
	} rtd_bus_req_t;
	typedef struct packed {
		rtd_fsm_t fsm;
		rtd_instr_t ins;
		logic [17:0] a;
		logic [17:0] b;
		logic [17:0] c;
		logic [17:0] q;
		logic [4:0] x;
		rtd_line_t y;
		logic plus;
		logic zero;
		logic even;
		logic cb1;
		logic cb2;
		logic par;
		rtd_line_t rx_s1;
		rtd_line_t rx_s2;
		rtd_line_t sw_s1;
		rtd_line_t sw_s2;
		rtd_line_t tx;
		logic tx_load;
		logic transmit_clear_pulse;
		logic receive_clear_pulse;
		logic [17:0] rdata;
	} rtd_state_t;
endpackage

// ### core/rtd_shifter.sv
// module: operation network between the intermediate register and the result drivers
`timescale 1ns/1ps
module rtd_shifter
(
	input wire rtd_pkg::rtd_op_t op,
	input wire logic [17:0] y,
	input wire logic link_bit,
	output logic [17:0] z
);
	localparam int W = rtd_pkg::DATA_W;
	localparam int S6 = rtd_pkg::SHIFT_SIX;

	always_comb
	begin
		case (op)
			rtd_pkg::pass_transfer_op:
				z = y;
			rtd_pkg::complement_transfer_op:
				z = ~y;
			rtd_pkg::shift_left_single_op:
				z = {y[W-2:0], 1'b0};
			rtd_pkg::shift_right_single_op:
				z = {1'b0, y[W-1:1]};
			rtd_pkg::shift_left_six_op:
				z = {y[W-S6-1:0], 6'h00};
			rtd_pkg::shift_right_six_op:
				z = {6'h00, y[W-1:S6]};
			rtd_pkg::rotate_left_single_op:
				z = {y[W-2:0], y[W-1]};
			rtd_pkg::rotate_right_single_op:
				z = {y[0], y[W-1:1]};
			rtd_pkg::rotate_left_six_op:
				z = {y[W-S6-1:0], y[W-1:W-S6]};
			rtd_pkg::rotate_right_six_op:
				z = {y[S6-1:0], y[W-1:S6]};
			rtd_pkg::linked_left_shift_op:
				z = {y[W-2:0], link_bit};
			default:
				z = y;
		endcase
	end
endmodule

// ### testbench/register_transfer_datapath_tb.sv
// testbench: instruction and register-port sequences with expected results
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module register_transfer_datapath_tb;
	logic clk;
	logic rst;
	logic instr_valid;
	rtd_pkg::rtd_instr_t instr;
	logic instr_ready;
	rtd_pkg::rtd_line_t rx_line;
	rtd_pkg::rtd_line_t switch_line;
	logic [4:0] line_addr;
	rtd_pkg::rtd_line_t tx_line;
	logic tx_load;
	logic receive_clear_pulse;
	logic transmit_clear_pulse;
	logic flag_plus;
	logic flag_zero;
	logic flag_even;
	rtd_pkg::rtd_bus_req_t bus;
	logic [17:0] rdata;
	int bad_count;
	int checks;
	logic [17:0] va;
	logic [17:0] vb;
	logic [17:0] exp;
	rtd_datapath DUT (.clk, .rst, .instr_valid, .instr, .instr_ready, .rx_line, .switch_line,
		.line_addr, .tx_line, .tx_load, .receive_clear_pulse, .transmit_clear_pulse,
		.flag_plus, .flag_zero, .flag_even, .bus, .rdata);
	rtd_line_model LINE (.clk, .rst, .line_addr, .tx_line, .tx_load, .receive_clear_pulse,
		.transmit_clear_pulse, .rx_line, .switch_line);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// access tasks
	task automatic wr(input logic [2:0] a, input logic [17:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [17:0] e);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 18'h00000};
		@(posedge clk);
		bus <= '0;
		#1;
		`CHK("rdata", e, rdata)
	endtask
	task automatic exec(input rtd_pkg::rtd_op_t op, input logic [10:1] sel);
		int n;
		repeat (3) @(posedge clk);
		instr_valid <= 1'b1;
		instr <= '{op: op, sel: sel};
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		for (n = 0; n < 6 && instr_ready !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		`CHK("latency", 2, n)
	endtask
	function automatic logic [17:0] f(input logic [3:0] op, input logic [17:0] y, input logic lk);
		case (op)
			4'h1: return ~y;
			4'h2: return y << 1;
			4'h3: return y >> 1;
			4'h4: return y << 6;
			4'h5: return y >> 6;
			4'h6: return {y[16:0], y[17]};
			4'h7: return {y[0], y[17:1]};
			4'h8: return {y[11:0], y[17:12]};
			4'h9: return {y[5:0], y[17:6]};
			4'hA: return {y[16:0], lk};
			default: return y;
		endcase
	endfunction
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
	// ==========================================================
	// tests
	initial
	begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = '0;
		bus = '0;
		bad_count = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 8; k++)
			rd(k[2:0], 18'h00000);
		$display("test reset done");
		va = 18'h2C0F3;
		vb = 18'h20001;
		wr(3'h0, va);
		wr(3'h1, vb);
		for (int k = 0; k < 11; k++)
		begin
			exp = f(k[3:0], va, vb[17]);
			exec(rtd_pkg::rtd_op_t'(k[3:0]), 10'h202);
			`CHK("flags", {~exp[17], exp == 18'h0, ~exp[0]}, {flag_plus, flag_zero, flag_even})
			rd(3'h2, exp);
		end
		rd(3'h0, va);
		$display("test operations done");
		wr(3'h3, 18'h00C00);
		exec(rtd_pkg::pass_transfer_op, 10'h346);
		rd(3'h1, 18'h2CCF3);
		rd(3'h2, 18'h2CCF3);
		rd(3'h0, va);
		rd(3'h3, 18'h00C00);
		exec(rtd_pkg::complement_transfer_op, 10'h008);
		rd(3'h0, 18'h3FFFF);
		exec(rtd_pkg::pass_transfer_op, 10'h000);
		`CHK("flags", 3'h7, {flag_plus, flag_zero, flag_even})
		rd(3'h0, 18'h3FFFF);
		rd(3'h1, 18'h2CCF3);
		$display("test groups done");
		wr(3'h4, 18'h00005);
		rd(3'h4, 18'h00005);
		`CHK("line_addr", 5'h05, line_addr)
		exec(rtd_pkg::pass_transfer_op, 10'h028);
		rd(3'h0, 18'h2AA05);
		rd(3'h5, 18'h00028);
		`CHK("rx_clears", 1, LINE.rx_clears)
		exec(rtd_pkg::pass_transfer_op, 10'h028);
		rd(3'h0, 18'h00000);
		rd(3'h5, 18'h00007);
		$display("test receive done");
		exec(rtd_pkg::pass_transfer_op, 10'h011);
		// the line model captures the load one edge after the destinations
		@(posedge clk);
		#1;
		`CHK("tx_line", 21'h08F0F0, LINE.tx_seen)
		`CHK("tx_order", 1'b1, LINE.tx_ok)
		rd(3'h5, 18'h00015);
		exec(rtd_pkg::pass_transfer_op, 10'h201);
		@(posedge clk);
		#1;
		`CHK("tx_line", 21'h080000, LINE.tx_seen)
		`CHK("tx_order", 1'b1, LINE.tx_ok)
		exec(rtd_pkg::linked_left_shift_op, 10'h208);
		rd(3'h0, 18'h00001);
		$display("test transmit done");
		report_and_stop();
	end
endmodule

// ### testbench/rtd_line_model.sv
// partner: line buffers and insert switches seen by the datapath
`timescale 1ns/1ps
module rtd_line_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] line_addr,
	input wire rtd_pkg::rtd_line_t tx_line,
	input wire logic tx_load,
	input wire logic receive_clear_pulse,
	input wire logic transmit_clear_pulse,
	output rtd_pkg::rtd_line_t rx_line,
	output rtd_pkg::rtd_line_t switch_line
);
	logic rx_full;
	logic tx_clr;
	logic tx_ok;
	rtd_pkg::rtd_line_t tx_seen;
	int rx_clears;
	// ==========================================================
	// receive buffer: word depends on the address, reads zero once cleared
	assign rx_line = rx_full ? {3'h5, 13'h1550, line_addr} : 21'h000000;
	assign switch_line = {3'h2, 18'h0F0F0};
	// ==========================================================
	// clear pulses and transmit capture
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_full <= 1'b1;
			tx_clr <= 1'b0;
			tx_ok <= 1'b0;
			tx_seen <= '0;
			rx_clears <= 0;
		end
		else
		begin
			if (receive_clear_pulse)
			begin
				rx_full <= 1'b0;
				rx_clears <= rx_clears + 1;
			end
			if (transmit_clear_pulse)
				tx_clr <= 1'b1;
			if (tx_load)
			begin
				tx_seen <= tx_line;
				// load only counts as clean when the clear came first
				tx_ok <= tx_clr;
				tx_clr <= 1'b0;
			end
		end
	end
endmodule
